// ==== logic/rsm_pkg.sv ====
// Functional notes
// - Enabled general outputs follow their register bits
// - Pin gives general_out0 (4-byte) or SA2 (8-byte)
// - Straps sampled at falling host reset edge
// - Read strap high: CD pins input SA12-SA15
// - Read strap low: CD pins act as CD-ROM
// - First nonzero modem base swaps DMA pins, sticky
// - Modem select on modem range; modem interrupt in
// - Volume enable forces shared pin to volume-down
// - Nonzero aux base makes pin aux select until host reset or a volume enable write
// - Otherwise write strap picks synth irq or general_out1
// - Synth select pin becomes volume-up when enabled
// - Host reset clears registers, disables devices, mutes
// - Reset release runs calibration, then bus isolation
// - Init length depends on serial memory contents
// - Power-down register gates internal blocks individually
// - ADC selector: line, aux1, mic, mixer
// - Microphone +20dB stage switchable by control bit
// - Mono attenuator: 16 levels of -3dB, mute
package rsm_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned HOST_WAIT_MS = 1000;
    localparam int unsigned CAL_TIME_MS = 500;
    localparam int unsigned CAL_CYCLES_DFLT = CAL_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned EE_BYTE_CYCLES_DFLT = 800;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODEM_BASE = 8'h04;
    localparam logic [7:0] OFS_AUX_BASE = 8'h08;
    localparam logic [7:0] OFS_PWRDN = 8'h0C;
    localparam logic [7:0] OFS_ANALOG = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    localparam int CTRL_HW_VOLUME_ENABLE = 0;
    localparam int CTRL_GPO_EN = 1;
    localparam int CTRL_GPO0 = 2;
    localparam int CTRL_GPO1 = 3;
    localparam int CTRL_RANGE8 = 4;
    localparam int CTRL_ACTIVATE = 5;
    localparam int CTRL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;

    localparam int BASE_W = 16;
    localparam logic [15:0] BASE_RST = 16'h0000;
    localparam int PWRDN_W = 8;
    localparam logic [7:0] PWRDN_RST = 8'h00;

    localparam int ANA_ADC_LSB = 0;
    localparam int ANA_MIC_BOOST = 2;
    localparam int ANA_ATT_LSB = 3;
    localparam int ANA_MONO_MUTE = 7;
    localparam int ANA_W = 8;
    localparam logic [7:0] ANA_RST = 8'h00;

    localparam logic [1:0] ADC_LINE = 2'h0;
    localparam logic [1:0] ADC_AUX1 = 2'h1;
    localparam logic [1:0] ADC_MIC = 2'h2;
    localparam logic [1:0] ADC_MIXER = 2'h3;

    localparam int NSYNC = 9;
    localparam int SY_HRST = 0;
    localparam int SY_STRAP_RD = 1;
    localparam int SY_STRAP_WR = 2;
    localparam int SY_CD_SEL = 3;
    localparam int SY_CD_ACK = 4;
    localparam int SY_CD_IRQ = 5;
    localparam int SY_CD_DRQ = 6;
    localparam int SY_SHARED = 7;
    localparam int SY_SYNTH = 8;

    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_INIT = 4'h2,
        ST_ISOL = 4'h4,
        ST_ACTIVE = 4'h8
    } rsm_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } rsm_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rsm_apb_rsp_type;

    typedef struct packed {
        logic o;
        logic oe_n;
    } rsm_pin_type;

endpackage : rsm_pkg

// ==== logic/rsm_strap_mux.sv ====
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ns
module rsm_strap_mux #(
    parameter int unsigned CAL_CYCLES = rsm_pkg::CAL_CYCLES_DFLT,
    parameter int unsigned EE_BYTE_CYCLES = rsm_pkg::EE_BYTE_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire rsm_pkg::rsm_apb_req_type apb_req,
    output rsm_pkg::rsm_apb_rsp_type apb_rsp,
    input wire logic host_reset_line,
    input wire logic periph_read_strobe_strap,
    input wire logic periph_write_strobe_strap,
    input wire logic [15:0] host_addr,
    input wire logic host_io_valid,
    input wire logic cd_sel_req,
    input wire logic cd_dack_req,
    input wire logic synth_sel_req,
    input wire logic ee_present,
    input wire logic [11:0] ee_bytes,
    input wire logic cd_select_i,
    input wire logic cd_dma_ack_i,
    input wire logic cd_irq_i,
    input wire logic cd_dma_req_i,
    input wire logic shared_pin_i,
    input wire logic synth_pin_i,
    output rsm_pkg::rsm_pin_type cd_select_pin,
    output rsm_pkg::rsm_pin_type cd_dma_ack_pin,
    output rsm_pkg::rsm_pin_type shared_pin,
    output rsm_pkg::rsm_pin_type synth_pin,
    output logic general_out0_pin,
    output logic [3:0] upper_addr,
    output logic upper_addr_ok,
    output logic cd_irq_out,
    output logic cd_drq_out,
    output logic modem_irq,
    output logic synth_irq_in,
    output logic vol_up_n,
    output logic vol_down_n,
    output logic dev_enable,
    output logic analog_mute,
    output logic [7:0] power_down,
    output logic [1:0] adc_source,
    output logic mic_boost,
    output logic [3:0] mono_atten,
    output logic mono_mute,
    output logic init_busy
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Base of zero never decodes; range is 4 or 8 bytes
    function automatic logic range_hit(input logic [15:0] addr, input logic [15:0] base,
                                       input logic eight);
        logic [15:0] mask;
        mask = eight ? 16'hFFF8 : 16'hFFFC;
        range_hit = (base != 16'h0000) && ((addr & mask) == (base & mask));
    endfunction : range_hit

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [rsm_pkg::NSYNC-1:0] sync1_r;
    logic [rsm_pkg::NSYNC-1:0] sync2_r;
    logic [rsm_pkg::NSYNC-1:0] pins_raw;
    logic hr_prev_r;

    assign pins_raw = {synth_pin_i, shared_pin_i, cd_dma_req_i, cd_irq_i, cd_dma_ack_i,
                       cd_select_i, periph_write_strobe_strap, periph_read_strobe_strap,
                       host_reset_line};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 9'h000;
            sync2_r <= 9'h000;
            hr_prev_r <= 1'b0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            hr_prev_r <= sync2_r[rsm_pkg::SY_HRST];
        end
    end

    wire hr_high = sync2_r[rsm_pkg::SY_HRST];
    wire hr_fall = hr_prev_r && !hr_high;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    // Pullups on both strap pins, so high is the idle answer
    logic strap_rd_r;
    logic strap_wr_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_rd_r <= 1'b1;
            strap_wr_r <= 1'b1;
        end else if (hr_fall) begin
            strap_rd_r <= sync2_r[rsm_pkg::SY_STRAP_RD];
            strap_wr_r <= sync2_r[rsm_pkg::SY_STRAP_WR];
        end
    end

    // ----------------------------------------------------------------
    // Reset / initialisation sequence
    // ----------------------------------------------------------------
    rsm_pkg::rsm_state_type state_r;
    rsm_pkg::rsm_state_type state_nxt;
    logic [31:0] init_cnt_r;
    logic [5:0] ctrl_r;
    wire [31:0] ee_cycles = ee_present ? 32'(ee_bytes) * 32'(EE_BYTE_CYCLES) : 32'h0;
    wire [31:0] init_load = 32'(CAL_CYCLES) + ee_cycles;
    wire init_done = (state_r == rsm_pkg::ST_INIT) && (init_cnt_r == 32'h0);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rsm_pkg::ST_RESET: if (hr_fall) state_nxt = rsm_pkg::ST_INIT;
            rsm_pkg::ST_INIT: if (init_done) state_nxt = rsm_pkg::ST_ISOL;
            rsm_pkg::ST_ISOL: if (ctrl_r[rsm_pkg::CTRL_ACTIVATE]) state_nxt = rsm_pkg::ST_ACTIVE;
            rsm_pkg::ST_ACTIVE: if (!ctrl_r[rsm_pkg::CTRL_ACTIVATE]) state_nxt = rsm_pkg::ST_ISOL;
            default: state_nxt = rsm_pkg::ST_RESET;
        endcase
        if (hr_high) begin
            state_nxt = rsm_pkg::ST_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= rsm_pkg::ST_RESET;
            init_cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            if (hr_fall) begin
                init_cnt_r <= init_load;
            end else if (state_r == rsm_pkg::ST_INIT && init_cnt_r != 32'h0) begin
                init_cnt_r <= init_cnt_r - 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB slave, one wait state
    // ----------------------------------------------------------------
    logic [15:0] modem_base_r;
    logic [15:0] aux_base_r;
    logic [7:0] pwrdn_r;
    logic [7:0] analog_r;
    logic modem_sw_r;
    logic aux_taken_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rd_mux;

    // Writes are refused until initialisation has finished
    wire regs_open = (state_r == rsm_pkg::ST_ISOL) || (state_r == rsm_pkg::ST_ACTIVE);
    wire sel_ctrl = apb_req.paddr == rsm_pkg::OFS_CTRL;
    wire sel_modem = apb_req.paddr == rsm_pkg::OFS_MODEM_BASE;
    wire sel_aux = apb_req.paddr == rsm_pkg::OFS_AUX_BASE;
    wire sel_pwrdn = apb_req.paddr == rsm_pkg::OFS_PWRDN;
    wire sel_analog = apb_req.paddr == rsm_pkg::OFS_ANALOG;
    wire sel_status = apb_req.paddr == rsm_pkg::OFS_STATUS;
    wire sel_any = sel_ctrl | sel_modem | sel_aux | sel_pwrdn | sel_analog | sel_status;
    wire acc_start = apb_req.psel && apb_req.penable && !pready_r;
    wire bad_acc = !sel_any || (apb_req.pwrite && (!regs_open || sel_status));
    wire wr_fire = apb_req.psel && apb_req.penable && pready_r && apb_req.pwrite && !pslverr_r;
    wire wr_ctrl = wr_fire && sel_ctrl;
    wire wr_modem = wr_fire && sel_modem;
    wire wr_aux = wr_fire && sel_aux;
    wire hw_volume_enable = ctrl_r[rsm_pkg::CTRL_HW_VOLUME_ENABLE];
    wire modem_set = wr_modem && (apb_req.pwdata[15:0] != 16'h0000) && !strap_rd_r;
    wire aux_set = wr_aux && (apb_req.pwdata[15:0] != 16'h0000);
    wire hw_volume_enable_set = wr_ctrl && apb_req.pwdata[rsm_pkg::CTRL_HW_VOLUME_ENABLE];
    wire [5:0] status_w = {init_busy, state_r == rsm_pkg::ST_ISOL, aux_taken_r, modem_sw_r,
                           strap_wr_r, strap_rd_r};

    always_comb begin
        rd_mux = 32'h0;
        case (1'b1)
            sel_ctrl: rd_mux = {26'h0, ctrl_r};
            sel_modem: rd_mux = {16'h0, modem_base_r};
            sel_aux: rd_mux = {16'h0, aux_base_r};
            sel_pwrdn: rd_mux = {24'h0, pwrdn_r};
            sel_analog: rd_mux = {24'h0, analog_r};
            sel_status: rd_mux = {26'h0, status_w};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= acc_start;
            pslverr_r <= acc_start && bad_acc;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= rsm_pkg::CTRL_RST;
            modem_base_r <= rsm_pkg::BASE_RST;
            aux_base_r <= rsm_pkg::BASE_RST;
            pwrdn_r <= rsm_pkg::PWRDN_RST;
            analog_r <= rsm_pkg::ANA_RST;
        end else if (state_r == rsm_pkg::ST_RESET) begin
            ctrl_r <= rsm_pkg::CTRL_RST;
            modem_base_r <= rsm_pkg::BASE_RST;
            aux_base_r <= rsm_pkg::BASE_RST;
            pwrdn_r <= rsm_pkg::PWRDN_RST;
            analog_r <= rsm_pkg::ANA_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= apb_req.pwdata[5:0];
            if (wr_modem) modem_base_r <= apb_req.pwdata[15:0];
            if (wr_aux) aux_base_r <= apb_req.pwdata[15:0];
            if (wr_fire && sel_pwrdn) pwrdn_r <= apb_req.pwdata[7:0];
            if (wr_fire && sel_analog) analog_r <= apb_req.pwdata[7:0];
        end
    end

    // Pin ownership flags; a set in the same cycle as a clear wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            modem_sw_r <= 1'b0;
            aux_taken_r <= 1'b0;
        end else begin
            if (modem_set) modem_sw_r <= 1'b1;
            else if (state_r == rsm_pkg::ST_RESET) modem_sw_r <= 1'b0;
            if (aux_set) aux_taken_r <= 1'b1;
            else if (state_r == rsm_pkg::ST_RESET || hw_volume_enable_set) aux_taken_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pin function selection
    // ----------------------------------------------------------------
    wire active = state_r == rsm_pkg::ST_ACTIVE;
    wire [3:0] upper_in = sync2_r[rsm_pkg::SY_CD_DRQ:rsm_pkg::SY_CD_SEL];
    // In address mode a decode with nonzero upper bits is an alias and is ignored
    wire upper_nxt_ok = !strap_rd_r || (upper_in == 4'h0);
    wire io_ok = active && host_io_valid && upper_nxt_ok;
    wire modem_hit = io_ok && modem_sw_r && range_hit(host_addr, modem_base_r, 1'b1);
    wire aux_hit = io_ok && range_hit(host_addr, aux_base_r, 1'b0);
    wire gpo_en = ctrl_r[rsm_pkg::CTRL_GPO_EN];
    wire gpo0_nxt = ctrl_r[rsm_pkg::CTRL_RANGE8] ? host_addr[2]
                                                 : gpo_en && ctrl_r[rsm_pkg::CTRL_GPO0];
    wire cd_port = !strap_rd_r;
    wire shared_in = sync2_r[rsm_pkg::SY_SHARED];
    wire synth_in = sync2_r[rsm_pkg::SY_SYNTH];
    wire shared_drives = !hw_volume_enable && (aux_taken_r || strap_wr_r);
    wire shared_o_nxt = aux_taken_r ? !aux_hit
                                    : gpo_en && ctrl_r[rsm_pkg::CTRL_GPO1];
    wire dack_o_nxt = modem_sw_r ? !modem_hit : cd_dack_req && active;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            general_out0_pin <= 1'b0;
            cd_select_pin <= '{o: 1'b0, oe_n: 1'b1};
            cd_dma_ack_pin <= '{o: 1'b0, oe_n: 1'b1};
            shared_pin <= '{o: 1'b0, oe_n: 1'b1};
            synth_pin <= '{o: 1'b1, oe_n: 1'b1};
            upper_addr <= 4'h0;
            upper_addr_ok <= 1'b1;
            cd_irq_out <= 1'b0;
            cd_drq_out <= 1'b0;
            modem_irq <= 1'b0;
            synth_irq_in <= 1'b0;
            vol_up_n <= 1'b1;
            vol_down_n <= 1'b1;
        end else begin
            general_out0_pin <= gpo0_nxt;
            cd_select_pin <= '{o: cd_sel_req && active, oe_n: !cd_port};
            cd_dma_ack_pin <= '{o: dack_o_nxt, oe_n: !cd_port};
            upper_addr <= cd_port ? 4'h0 : upper_in;
            upper_addr_ok <= upper_nxt_ok;
            cd_irq_out <= cd_port && sync2_r[rsm_pkg::SY_CD_IRQ];
            cd_drq_out <= cd_port && !modem_sw_r && sync2_r[rsm_pkg::SY_CD_DRQ];
            modem_irq <= cd_port && modem_sw_r && sync2_r[rsm_pkg::SY_CD_DRQ];
            shared_pin <= '{o: shared_o_nxt, oe_n: !shared_drives};
            synth_irq_in <= !hw_volume_enable && !aux_taken_r && !strap_wr_r && shared_in;
            vol_down_n <= hw_volume_enable ? shared_in : 1'b1;
            synth_pin <= '{o: !(synth_sel_req && active), oe_n: hw_volume_enable};
            vol_up_n <= hw_volume_enable ? synth_in : 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Device and analog controls
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_enable <= 1'b0;
            analog_mute <= 1'b1;
            init_busy <= 1'b0;
            power_down <= rsm_pkg::PWRDN_RST;
            adc_source <= rsm_pkg::ADC_LINE;
            mic_boost <= 1'b0;
            mono_atten <= 4'h0;
            mono_mute <= 1'b0;
            apb_rsp <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
        end else begin
            dev_enable <= state_nxt == rsm_pkg::ST_ACTIVE;
            analog_mute <= state_nxt != rsm_pkg::ST_ACTIVE;
            init_busy <= state_nxt == rsm_pkg::ST_INIT;
            power_down <= pwrdn_r;
            adc_source <= analog_r[rsm_pkg::ANA_ADC_LSB +: 2];
            mic_boost <= analog_r[rsm_pkg::ANA_MIC_BOOST];
            mono_atten <= analog_r[rsm_pkg::ANA_ATT_LSB +: 4];
            mono_mute <= analog_r[rsm_pkg::ANA_MONO_MUTE];
            apb_rsp <= '{prdata: rd_mux, pready: acc_start, pslverr: acc_start && bad_acc};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_strap_sample: assert property (hr_fall |=> strap_rd_r == $past(sync2_r[1]))
        else $error("read strap not sampled at reset fall");
    a_strap_hold: assert property (!hr_fall |=> $stable(strap_rd_r) && $stable(strap_wr_r))
        else $error("strap level changed outside reset fall");
    a_addr_mode_in: assert property (strap_rd_r |=>
        cd_select_pin.oe_n && cd_dma_ack_pin.oe_n)
        else $error("CD pins driven in address mode");
    a_cd_port_out: assert property (!strap_rd_r && $stable(strap_rd_r) |=>
        !cd_dma_ack_pin.oe_n)
        else $error("CD port pin not driven");
    a_modem_sticky: assert property (modem_sw_r && state_r != rsm_pkg::ST_RESET |=>
        modem_sw_r)
        else $error("modem switch dropped without reset");
    a_modem_sel: assert property (modem_hit |=> !cd_dma_ack_pin.o [*1])
        else $error("modem select not asserted on hit");
    a_vol_down: assert property (hw_volume_enable |=> shared_pin.oe_n && vol_down_n == $past(shared_in))
        else $error("volume-down override lost");
    a_aux_select: assert property (!hw_volume_enable && aux_taken_r |=> !shared_pin.oe_n)
        else $error("aux select not driven");
    a_synth_irq: assert property (!hw_volume_enable && !aux_taken_r && !strap_wr_r |=> shared_pin.oe_n)
        else $error("synth irq pin driven");
    a_vol_up: assert property (hw_volume_enable |=> synth_pin.oe_n)
        else $error("volume-up pin driven");
    a_gpo_drive: assert property (!ctrl_r[4] |=>
        general_out0_pin == $past(gpo_en && ctrl_r[2]))
        else $error("general output 0 wrong");
    a_sa2_route: assert property (ctrl_r[4] |=> general_out0_pin == $past(host_addr[2]))
        else $error("SA2 not routed");
    a_reset_mute: assert property (hr_high |=> ##1 analog_mute && !dev_enable)
        else $error("not muted under host reset");
    a_init_exit: assert property (state_r == rsm_pkg::ST_INIT && init_cnt_r != 32'h0
                                  && !hr_high |=> state_r == rsm_pkg::ST_INIT)
        else $error("init ended early");
    a_regs_clear: assert property (state_r == rsm_pkg::ST_RESET
        |=> ctrl_r == rsm_pkg::CTRL_RST && pwrdn_r == rsm_pkg::PWRDN_RST)
        else $error("registers not cleared under host reset");
    a_init_load: assert property (hr_fall |=> init_cnt_r == $past(init_load))
        else $error("init length not loaded at reset fall");
    a_upper_gate: assert property (strap_rd_r && upper_in != 4'h0 |=> !upper_addr_ok)
        else $error("nonzero upper address accepted");
    a_modem_irq_in: assert property (modem_sw_r |=> !cd_drq_out)
        else $error("CD DMA request seen after modem switch");
    a_pwrdn_copy: assert property (1'b1 |=> power_down == $past(pwrdn_r))
        else $error("power-down bits not applied");
    a_mono_copy: assert property (1'b1 |=>
        mono_atten == $past(analog_r[rsm_pkg::ANA_ATT_LSB +: 4])
        && mono_mute == $past(analog_r[rsm_pkg::ANA_MONO_MUTE]))
        else $error("mono attenuator setting not applied");

    c_modem_swap: cover property (modem_set);
    c_aux_take: cover property (aux_set && !hw_volume_enable);
    c_init_done: cover property (init_done ##1 state_r == rsm_pkg::ST_ISOL);
    c_vol_mode: cover property (hw_volume_enable_set);
    c_addr_mode: cover property (hr_fall && sync2_r[rsm_pkg::SY_STRAP_RD]);

endmodule : rsm_strap_mux

// ==== verif/rsm_far_end.sv ====
`timescale 1ns/1ns
module rsm_far_end (
    input wire rsm_pkg::rsm_pin_type sel_pin,
    input wire rsm_pkg::rsm_pin_type ack_pin,
    input wire rsm_pkg::rsm_pin_type shr_pin,
    input wire rsm_pkg::rsm_pin_type syn_pin,
    input wire logic [5:0] lv,
    output logic [5:0] pin_i
);
    // ----------------------------------------------------------------
    // Wire levels
    // ----------------------------------------------------------------
    // A released line shows the peripheral or pull-up level, never the last drive
    assign pin_i[0] = sel_pin.oe_n ? lv[0] : sel_pin.o;
    assign pin_i[1] = ack_pin.oe_n ? lv[1] : ack_pin.o;
    assign pin_i[2] = lv[2];
    assign pin_i[3] = lv[3];
    assign pin_i[4] = shr_pin.oe_n ? lv[4] : shr_pin.o;
    assign pin_i[5] = syn_pin.oe_n ? lv[5] : syn_pin.o;
endmodule : rsm_far_end

// ==== verif/test_reset_strap_pin_mux.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_reset_strap_pin_mux;
    // ----------------------------------------------------------------
    // Bench state
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hrst = 1'b1;
    logic srd = 1'b0;
    logic swr = 1'b1;
    logic hval = 1'b0;
    logic [15:0] haddr = 16'h0000;
    logic [5:0] lv = 6'h3F;
    rsm_pkg::rsm_apb_req_type req = '0;
    rsm_pkg::rsm_apb_rsp_type rsp;
    rsm_pkg::rsm_pin_type p_sel, p_ack, p_shr, p_syn;
    logic [5:0] pin_i;
    logic [3:0] up_a, att;
    logic [7:0] pd;
    logic [1:0] adc;
    logic g0, mirq, sirq, vup, vdn, den, mute, busy, boost, mmute, err, uok, cirq, cd_dma_req;
    logic [2:0] sreq = 3'h0;
    logic [31:0] rd;
    int num_errors = 0;
    int checks = 0;
    always #25 clk = ~clk;
    rsm_strap_mux #(.CAL_CYCLES(20), .EE_BYTE_CYCLES(2)) dut_u (
        .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .host_reset_line(hrst),
        .periph_read_strobe_strap(srd), .periph_write_strobe_strap(swr),
        .host_addr(haddr), .host_io_valid(hval), .cd_sel_req(sreq[0]), .cd_dack_req(sreq[1]),
        .synth_sel_req(sreq[2]), .ee_present(1'b1), .ee_bytes(12'h005),
        .cd_select_i(pin_i[0]), .cd_dma_ack_i(pin_i[1]), .cd_irq_i(pin_i[2]),
        .cd_dma_req_i(pin_i[3]), .shared_pin_i(pin_i[4]), .synth_pin_i(pin_i[5]),
        .cd_select_pin(p_sel), .cd_dma_ack_pin(p_ack), .shared_pin(p_shr), .synth_pin(p_syn),
        .general_out0_pin(g0), .upper_addr(up_a), .upper_addr_ok(uok), .cd_irq_out(cirq),
        .cd_drq_out(cd_dma_req), .modem_irq(mirq), .synth_irq_in(sirq), .vol_up_n(vup),
        .vol_down_n(vdn), .dev_enable(den), .analog_mute(mute), .power_down(pd),
        .adc_source(adc), .mic_boost(boost), .mono_atten(att), .mono_mute(mmute),
        .init_busy(busy));
    rsm_far_end far_u (.sel_pin(p_sel), .ack_pin(p_ack), .shr_pin(p_shr), .syn_pin(p_syn),
        .lv(lv), .pin_i(pin_i));
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic results;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (n >= 20) begin
            num_errors++;
            results();
        end
    endtask : apb
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_host_reset(input logic rd_s, input logic wr_s);
        int n;
        n = 0;
        hrst <= 1'b1;
        settle();
        `CHK({mute, den}, 2'b10)
        apb(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_0021);
        `CHK(err, 1'b1)
        srd <= rd_s;
        swr <= wr_s;
        settle();
        hrst <= 1'b0;
        settle();
        srd <= ~rd_s;
        swr <= ~wr_s;
        while (busy === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        `CHK(n >= 20 && n < 40, 1'b1)
        if (n >= 200) results();
        apb(1'b0, rsm_pkg::OFS_CTRL, 32'h0);
        `CHK(rd[5:0], rsm_pkg::CTRL_RST)
        apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
        `CHK(rd[4:0], {3'b100, wr_s, rd_s})
        apb(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_002A);
        `CHK(err, 1'b0)
    endtask : t_host_reset
    task automatic t_modem_and_outs;
        lv[3:0] <= 4'hF;
        sreq <= 3'h7;
        settle();
        `CHK({up_a, mirq, p_shr.oe_n, p_shr.o, g0}, 8'b0000_0010)
        `CHK({uok, cirq, cd_dma_req}, 3'b111)
        `CHK({p_sel.o, p_ack.o, p_syn.oe_n, p_syn.o}, 4'b1100)
        sreq <= 3'h0;
        apb(1'b1, rsm_pkg::OFS_MODEM_BASE, 32'h0000_0300);
        haddr <= 16'h0305;
        hval <= 1'b1;
        settle();
        `CHK({p_ack.oe_n, p_ack.o, mirq, cd_dma_req}, 4'b0010)
        haddr <= 16'h0308;
        apb(1'b1, rsm_pkg::OFS_MODEM_BASE, 32'h0);
        settle();
        `CHK({p_ack.oe_n, p_ack.o}, 2'b01)
        apb(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_003E);
        haddr <= 16'h0004;
        settle();
        `CHK(g0, 1'b1)
        haddr <= 16'h0220;
        settle();
        `CHK(g0, 1'b0)
        apb(1'b1, rsm_pkg::OFS_AUX_BASE, 32'h0000_0220);
        settle();
        `CHK({p_shr.oe_n, p_shr.o}, 2'b00)
        apb(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_0021);
        lv[5:4] <= 2'b00;
        settle();
        `CHK({p_shr.oe_n, p_syn.oe_n, vdn, vup}, 4'b1100)
        lv[5:4] <= 2'b11;
        apb(1'b1, rsm_pkg::OFS_CTRL, 32'h0000_002A);
        settle();
        `CHK({p_shr.oe_n, p_shr.o, vdn, vup}, 4'b0111)
    endtask : t_modem_and_outs
    task automatic t_upper_addr;
        lv[3:0] <= 4'hA;
        settle();
        `CHK({up_a, p_sel.oe_n, sirq, uok}, 7'b1010_110)
    endtask : t_upper_addr
    task automatic t_analog;
        for (int i = 0; i < 4; i++) begin
            logic [7:0] v;
            v = {i[0], 4'(15 - i * 5), i[1], i[1:0]};
            apb(1'b1, rsm_pkg::OFS_ANALOG, {24'h0, v});
            settle();
            `CHK({mmute, att, boost, adc}, v)
        end
        apb(1'b1, rsm_pkg::OFS_PWRDN, 32'h0000_00A5);
        settle();
        `CHK(pd, 8'hA5)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, rsm_pkg::OFS_STATUS, 32'h0);
        `CHK(err, 1'b1)
    endtask : t_analog
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_host_reset(1'b0, 1'b1);
        t_modem_and_outs();
        t_analog();
        t_host_reset(1'b1, 1'b0);
        t_upper_addr();
        results();
    end
endmodule : test_reset_strap_pin_mux
